// >>> asr_defs.vh
// Purpose: constants for the serial converter slave interface
// Assumes: 125 MHz system clock
// Notes: definitions only
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH
`define ASR_CLK_PERIOD_NS 8
`define ASR_TIMEOUT_MS 28
`define ASR_TIMEOUT_CYC ((`ASR_TIMEOUT_MS * 1000000) / `ASR_CLK_PERIOD_NS)
`define ASR_WORD_BITS 16
`define ASR_CFG_RESET 16'h058B
`define ASR_CFG_PULLUP_BIT 3
`define ASR_CFG_WVALID_HI 2
`define ASR_CFG_WVALID_LO 1
`define ASR_WVALID_OK 2'h1
`define ASR_CFG_MUX_HI 14
`define ASR_CFG_MUX_LO 12
`define ASR_CFG_SS_BIT 15
`define ASR_CFG_RSVD_BIT 0
`endif

// >>> asr_sync3.v
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes: output changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module asr_sync3 (
  input wire clk, // System clock
  input wire rst_n, // Async reset, active low
  input wire clkEn, // Freezes state when low
  input wire rstVal, // Value taken at reset release
  input wire din, // Asynchronous input
  output reg dout // Filtered level
);
  reg s1Q;
  reg s2Q;
  reg s3Q;
  reg initQ;

  // Stage one only feeds stage two; filter reads stages two and three
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1Q <= 1'b0;
      s2Q <= 1'b0;
      s3Q <= 1'b0;
      dout <= 1'b0;
      initQ <= 1'b0;
    end
    else if (clkEn)
    begin
      s1Q <= din;
      initQ <= 1'b1;
      if (!initQ)
      begin
        // Preload the filter so stale zeros cannot undo the reset level
        s2Q <= rstVal;
        s3Q <= rstVal;
        dout <= rstVal;
      end
      else
      begin
        s2Q <= s1Q;
        s3Q <= s2Q;
        if (s2Q == s3Q)
          dout <= s3Q;
      end
    end
  end
endmodule
`default_nettype wire

// >>> asr_buf2.v
// Purpose: two-entry buffer between converter results and the shifter
// Assumes: same clock on both sides
// Notes: honest full and empty; drain may stall
`timescale 1ns/10ps
`default_nettype none
module asr_buf2 (
  input wire clk, // System clock
  input wire rst_n, // Async reset, active low
  input wire clkEn, // Freezes state when low
  input wire [15:0] inData, // Word in
  input wire inValid, // Word in valid
  output wire inReady, // Room available
  output wire [15:0] outData, // Oldest word
  output wire outValid, // Buffer not empty
  input wire outReady // Drain accepts
);
  reg [15:0] memQ [0:1];
  reg wrPtrQ;
  reg rdPtrQ;
  reg [1:0] cntQ;
  wire doWr;
  wire doRd;

  assign inReady = (cntQ != 2'h2);
  assign outValid = (cntQ != 2'h0);
  assign outData = memQ[rdPtrQ];
  assign doWr = inValid & inReady;
  assign doRd = outValid & outReady;

  // Pointer and count update; a full buffer pushes back on the source
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtrQ <= 1'b0;
      rdPtrQ <= 1'b0;
      cntQ <= 2'h0;
      memQ[0] <= 16'h0000;
      memQ[1] <= 16'h0000;
    end
    else if (clkEn)
    begin
      if (doWr)
      begin
        memQ[wrPtrQ] <= inData;
        wrPtrQ <= ~wrPtrQ;
      end
      if (doRd)
        rdPtrQ <= ~rdPtrQ;
      if (doWr & ~doRd)
        cntQ <= cntQ + 2'h1;
      else if (doRd & ~doWr)
        cntQ <= cntQ - 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> asr_spi_slave.v
// Purpose: serial slave of a 16-bit converter with combined data/ready line
// Assumes: sclk, csN, din from pins; results arrive on system clock
// Notes: mode 1 link sampled by clk; edges seen a few cycles late
// Notes on behaviour
// RQ1: Clock idles low; bits change on rising, sampled on falling edges.
// RQ2: Transfer abandoned when serial clock stays low longer than 28 ms.
// RQ3: Host gives each device its own chip select on shared buses.
// RQ4: Deselected with pullup disabled, output line floats.
// RQ5: No ready signalling on the output line while chip select is high.
// RQ6: Chip select falling drives the line to a definite level at once.
// RQ7: Line driven low after select when an unread result is waiting.
// RQ8: Line high when nothing new; clocking repeats the previous result.
// RQ9: Result arriving mid-transfer waits for the next framed transfer.
// RQ10: Every read returns an uncorrupted, whole result word.
// RQ11: Selector offers inputs zero, one, two against input three.
// RQ12: Selector offers each input alone against ground.
// RQ13: Configuration updated only when write-valid bits equal 01.
// RQ14: Pullup enable is configuration bit 3, reset 1, active while deselected.
// RQ15: Result shifted out MSB first while configuration word shifts in.
`timescale 1ns/10ps
`default_nettype none
`include "asr_defs.vh"
module asr_spi_slave #(
  parameter [31:0] TIMEOUT_CYC = `ASR_TIMEOUT_CYC
) (
  input wire clk, // System clock, 125 MHz
  input wire rst_n, // Async reset, active low
  input wire clkEn, // Freezes all state when low
  input wire sclk, // Serial clock pin
  input wire csN, // Chip select pin, active low
  input wire din, // Host-to-device data pin
  output reg dataOutReadyLineO, // Combined data/ready output level
  output reg dataOutReadyLineOe, // High while the line is driven
  output reg pullupOn, // Weak pullup active
  input wire [15:0] resultData, // New conversion result
  input wire resultValid, // Result strobe
  output reg resultReady, // Result accepted by buffer path
  output reg [15:0] cfgWord, // Stored configuration word
  output reg [2:0] inputSel, // Selector field of configuration
  output reg cfgWrite, // Pulse when configuration updated
  output reg timeoutHit // Pulse when a transfer was abandoned
);
  // Frame states
  localparam ST_IDLE = 2'h0;
  localparam ST_XFER = 2'h1;
  localparam ST_DONE = 2'h2;

  // Synchronised pins and buffer handshake
  wire sclkS;
  wire csNS;
  wire dinS;
  wire bufInReady;
  wire [15:0] bufData;
  wire bufValid;
  reg bufPop;
  // Shift path, held results and counters
  reg [1:0] stQ;
  reg [1:0] stD;
  reg sclkPrevQ;
  reg [15:0] shOutQ;
  reg [15:0] shInQ;
  reg [15:0] lastQ;
  reg [15:0] pendQ;
  reg pendValidQ;
  reg [4:0] bitCntQ;
  reg [31:0] idleCntQ;
  wire sclkRise;
  wire sclkFall;

  // Selector code tests: three-input common point and ground-referenced
  function isCommonPoint;
    input [2:0] sel;
    begin
      isCommonPoint = (sel == 3'h1) | (sel == 3'h2) | (sel == 3'h3);
    end
  endfunction

  // Upper half of the selector codes measures one input against ground
  function isGroundRef;
    input [2:0] sel;
    begin
      isGroundRef = (sel[2] == 1'b1);
    end
  endfunction

  // Pullup level while deselected, from the stored configuration
  function pullLevel;
    input [15:0] cfg;
    begin
      pullLevel = cfg[`ASR_CFG_PULLUP_BIT];
    end
  endfunction

  // Write-valid field of a shifted-in word
  function wvalidOk;
    input [15:0] word;
    begin
      wvalidOk = (word[`ASR_CFG_WVALID_HI:`ASR_CFG_WVALID_LO] ==
        `ASR_WVALID_OK);
    end
  endfunction

  // Serial clock parked low for too long
  function idleExpired;
    input [31:0] cnt;
    begin
      idleExpired = (cnt >= TIMEOUT_CYC);
    end
  endfunction

  // Whole word clocked in
  function wordDone;
    input [4:0] cnt;
    begin
      wordDone = (cnt == `ASR_WORD_BITS);
    end
  endfunction

  // Pin inputs; chip select loads deselected on the first clock after reset release
  asr_sync3 uSyncSclk (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .rstVal(1'b0), .din(sclk), .dout(sclkS));
  asr_sync3 uSyncCs (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .rstVal(1'b1), .din(csN), .dout(csNS));
  asr_sync3 uSyncDin (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .rstVal(1'b0), .din(din), .dout(dinS));

  // Results queue here so a busy shifter loses no word while fewer than two are waiting
  asr_buf2 uBuf (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .inData(resultData), .inValid(resultValid), .inReady(bufInReady),
    .outData(bufData), .outValid(bufValid), .outReady(bufPop));

  // Edge detectors; the previous level resets to the idle low clock
  assign sclkRise = sclkS & ~sclkPrevQ; // RQ1
  assign sclkFall = ~sclkS & sclkPrevQ; // RQ1

  // Latest-result holder drains buffer only outside a frame
  always @*
  begin
    bufPop = bufValid & (stQ == ST_IDLE) & csNS & ~pendValidQ; // RQ9
  end

  // Frame sequencing
  always @*
  begin
    stD = stQ;
    case (stQ)
      ST_IDLE:
        if (!csNS)
          stD = ST_XFER;
      ST_XFER:
        if (csNS)
          stD = ST_IDLE;
        else if (idleExpired(idleCntQ))
          stD = ST_DONE; // RQ2
        else if (wordDone(bitCntQ))
          stD = ST_DONE;
      ST_DONE:
        if (csNS)
          stD = ST_IDLE;
      default:
        stD = ST_IDLE;
    endcase
  end

  // Frame datapath: line level, shifters and configuration store
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stQ <= ST_IDLE;
      sclkPrevQ <= 1'b0;
      shOutQ <= 16'h0000;
      shInQ <= 16'h0000;
      lastQ <= 16'h0000;
      pendQ <= 16'h0000;
      pendValidQ <= 1'b0;
      bitCntQ <= 5'd0;
      idleCntQ <= 32'h0000_0000;
      cfgWord <= `ASR_CFG_RESET;
      inputSel <= 3'h0;
      cfgWrite <= 1'b0;
      timeoutHit <= 1'b0;
      resultReady <= 1'b0;
      dataOutReadyLineO <= 1'b1;
      dataOutReadyLineOe <= 1'b0;
      pullupOn <= 1'b1;
    end
    else if (clkEn)
    begin
      stQ <= stD;
      sclkPrevQ <= sclkS;
      cfgWrite <= 1'b0;
      timeoutHit <= 1'b0;
      resultReady <= resultValid & bufInReady;
      inputSel <= cfgWord[`ASR_CFG_MUX_HI:`ASR_CFG_MUX_LO];
      // Whole words only: new data never alters a frame in progress
      if (bufPop)
      begin
        pendQ <= bufData; // RQ10
        pendValidQ <= 1'b1;
      end
      case (stQ)
        ST_IDLE:
        begin
          dataOutReadyLineOe <= 1'b0; // RQ5
          pullupOn <= pullLevel(cfgWord); // RQ4 RQ14
          bitCntQ <= 5'd0;
          idleCntQ <= 32'h0000_0000;
          if (!csNS)
          begin
            // Freeze outgoing word at frame start
            dataOutReadyLineOe <= 1'b1; // RQ6
            pullupOn <= 1'b0; // RQ14
            if (pendValidQ)
            begin
              shOutQ <= pendQ; // RQ7 RQ9
              lastQ <= pendQ;
              pendValidQ <= 1'b0;
              dataOutReadyLineO <= 1'b0; // RQ7
            end
            else
            begin
              shOutQ <= lastQ; // RQ8
              dataOutReadyLineO <= 1'b1; // RQ8
            end
          end
        end
        ST_XFER:
        begin
          // Low time counts from select, so a host that never clocks ends too
          if (sclkS)
            idleCntQ <= 32'h0000_0000;
          else
            idleCntQ <= idleCntQ + 32'h0000_0001; // RQ2
          if (sclkRise)
          begin
            dataOutReadyLineO <= shOutQ[15]; // RQ1 RQ15
            shOutQ <= {shOutQ[14:0], 1'b0}; // RQ15
          end
          if (sclkFall)
          begin
            shInQ <= {shInQ[14:0], dinS}; // RQ1 RQ15
            bitCntQ <= bitCntQ + 5'd1;
          end
          if (stD == ST_DONE && idleExpired(idleCntQ))
            timeoutHit <= 1'b1; // RQ2
          else if (stD == ST_DONE && wvalidOk(shInQ))
          begin
            // Start bit reads back zero, reserved bit reads one
            cfgWord <= {1'b0, shInQ[14:1], 1'b1}; // RQ13
            cfgWrite <= 1'b1; // RQ13
          end
          if (csNS)
          begin
            dataOutReadyLineOe <= 1'b0; // RQ5
            pullupOn <= pullLevel(cfgWord); // RQ4
          end
        end
        ST_DONE:
        begin
          // Line stays driven until deselect; further clocks ignored
          if (csNS)
          begin
            dataOutReadyLineOe <= 1'b0; // RQ4 RQ5
            pullupOn <= pullLevel(cfgWord); // RQ14
          end
        end
        default:
          dataOutReadyLineOe <= 1'b0;
      endcase
    end
  end

  // Selector class flags feed nothing else; only inputSel leaves the module
  wire selCommon;
  wire selGround;
  wire unusedSel;
  assign selCommon = isCommonPoint(inputSel); // RQ11
  assign selGround = isGroundRef(inputSel); // RQ12
  assign unusedSel = selCommon | selGround;
endmodule
`default_nettype wire

// >>> asr_spi_props.sv
// Purpose: port checks on the converter serial slave
// Assumes: pins reach the logic through a few synchroniser stages
// Notes: six-cycle windows absorb the synchroniser delay
`timescale 1ns/10ps
`default_nettype none
module asr_spi_props #(
  parameter [31:0] TIMEOUT_CYC = 200
) (
  input wire clk, // System clock
  input wire rst_n, // Async reset
  input wire sclk, // Serial clock pin
  input wire csN, // Chip select pin
  input wire dataOutReadyLineO, // Line level
  input wire dataOutReadyLineOe, // Line driven
  input wire pullupOn, // Weak pullup
  input wire [15:0] cfgWord, // Stored configuration
  input wire [2:0] inputSel, // Selector field
  input wire cfgWrite, // Configuration written
  input wire timeoutHit // Transfer abandoned
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [31:0] lowCnt;
  // Raw low time runs ahead of the design's synchronised count
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      lowCnt <= 32'h0000_0000;
    else if (sclk)
      lowCnt <= 32'h0000_0000;
    else
      lowCnt <= lowCnt + 32'h0000_0001;
  // Steps: settled deselect, and a bit change inside a frame
  sequence s_desel;
    csN [*6];
  endsequence
  sequence s_shift;
    dataOutReadyLineOe && $past(dataOutReadyLineOe)
      && $changed(dataOutReadyLineO);
  endsequence
  // Line ownership around chip select
  a_no_ready_desel: assert property (s_desel |-> !dataOutReadyLineOe)
    else $error("line driven while deselected");
  a_float_off: assert property (s_desel ##0 !cfgWord[3] |-> !pullupOn)
    else $error("pullup on although disabled");
  a_pullup_cfg: assert property (s_desel |-> pullupOn == cfgWord[3])
    else $error("pullup differs from its enable");
  a_pullup_excl: assert property (pullupOn |-> !dataOutReadyLineOe)
    else $error("pullup while selected");
  a_drive_on_sel: assert property ($fell(csN) |-> ##[1:6] dataOutReadyLineOe)
    else $error("line not driven after select");
  // Bits move only after a serial clock rise
  a_bit_on_rise: assert property (s_shift |->
    $past(sclk, 3) || $past(sclk, 4) || $past(sclk, 5))
    else $error("data changed without a rising clock");
  // Configuration store
  a_cfg_shape: assert property (!cfgWord[15] && cfgWord[2:1] == 2'h1
    && cfgWord[0])
    else $error("stored configuration malformed");
  a_cfg_on_write: assert property (!$stable(cfgWord) |->
    cfgWrite || $past(cfgWrite))
    else $error("configuration changed without a write");
  a_sel_follow: assert property (inputSel == $past(cfgWord[14:12]))
    else $error("selector does not follow configuration");
  a_timeout_late: assert property (timeoutHit |->
    !sclk && lowCnt >= TIMEOUT_CYC - 2)
    else $error("transfer abandoned too early");
endmodule
`default_nettype wire

// >>> asr_host_model.sv
// Purpose: mode 1 host driving the serial link
// Assumes: the bench resolves the shared data/ready line
// Notes: clock high 40 ns, low 24 ns, so late bits are still caught
`timescale 1ns/10ps
`default_nettype none
module asr_host_model (
  input wire logic clk, // System clock
  input wire logic line, // Resolved data/ready line
  output var logic sclk, // Serial clock
  output var logic csN, // Own chip select
  output var logic din // Host data out
);
  // Idle low clock, deselected
  initial {sclk, csN, din} = 3'b010;
  // Selects, reads ready, then shifts nBits MSB first; stays selected
  task automatic xfer(input logic [15:0] tx, input int nBits,
    output logic [15:0] rx, output logic rdy);
    rx = 16'h0000;
    @(posedge clk);
    #1 csN = 1'b0;
    repeat (6) @(posedge clk);
    #1 rdy = line;
    for (int i = 15; i > 15 - nBits; i--)
    begin
      sclk = 1'b1;
      din = tx[i];
      repeat (5) @(posedge clk);
      #1 rx[i] = line;
      sclk = 1'b0;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  // Deselect and let the synchroniser settle
  task automatic done;
    csN = 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> asr_tb.sv
// Purpose: self-checking bench for the converter serial slave
// Assumes: abandon time shortened to 200 cycles
// Notes: undriven line without pullup shows the inverse of its last level
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [15:0] resData = 16'h0000;
  logic resValid = 1'b0;
  logic sclk, csN, din, lineO, lineOe, pullOn, resReady, cfgWr, toHit;
  logic [15:0] cfg;
  logic [2:0] sel;
  logic lastLvl = 1'b0;
  logic line;
  int n_errors = 0;
  int samples_checked = 0;
  // Clock and line resolution
  always #4 clk = ~clk;
  always @(posedge clk) if (lineOe) lastLvl <= lineO;
  assign line = lineOe ? lineO : (pullOn ? 1'b1 : ~lastLvl);
  asr_spi_slave #(.TIMEOUT_CYC(200)) i_dut (.clk(clk), .rst_n(rst_n),
    .clkEn(clkEn), .sclk(sclk), .csN(csN), .din(din),
    .dataOutReadyLineO(lineO), .dataOutReadyLineOe(lineOe),
    .pullupOn(pullOn), .resultData(resData), .resultValid(resValid),
    .resultReady(resReady), .cfgWord(cfg), .inputSel(sel),
    .cfgWrite(cfgWr), .timeoutHit(toHit));
  asr_host_model hm (.clk(clk), .line(line), .sclk(sclk), .csN(csN),
    .din(din));
  task automatic results;
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One converter result strobe
  task automatic push(input logic [15:0] w);
    @(posedge clk);
    #1 resData = w;
    resValid = 1'b1;
    @(posedge clk);
    #1 resValid = 1'b0;
    chk(resReady, 1'b1);
  endtask
  // Whole framed transfer, then deselected state
  task automatic frame(input logic [15:0] tx, exRx, input logic exRdy,
    input logic [15:0] exCfg);
    logic [15:0] rx;
    logic rdy;
    hm.xfer(tx, 16, rx, rdy);
    hm.done();
    chk(rdy, exRdy);
    chk(rx, exRx);
    chk(cfg, exCfg);
    chk(pullOn, exCfg[3]);
    chk(lineOe, 1'b0);
  endtask
  task automatic t_fresh;
    push(16'hA5C3);
    frame(16'h1582, 16'hA5C3, 1'b0, 16'h1583);
    chk(sel, 3'h1);
  endtask
  task automatic t_stale;
    frame(16'h458C, 16'hA5C3, 1'b1, 16'h1583);
  endtask
  // Two results land mid-frame and queue behind it
  task automatic t_mid;
    fork
      frame(16'h458A, 16'hA5C3, 1'b1, 16'h458B);
      begin
        repeat (40) @(posedge clk);
        push(16'h8001);
        push(16'h7FFE);
      end
    join
    chk(sel, 3'h4);
    frame(16'h0000, 16'h8001, 1'b0, 16'h458B);
    frame(16'h0000, 16'h7FFE, 1'b0, 16'h458B);
  endtask
  // Clock parked low mid-transfer
  task automatic t_timeout;
    logic [15:0] rx;
    logic rdy;
    int k;
    k = 0;
    hm.xfer(16'h0000, 4, rx, rdy);
    while (toHit !== 1'b1 && k < 400)
    begin
      @(posedge clk);
      #1 k++;
    end
    chk(k >= 185 && k <= 215, 1'b1);
    if (k == 400)
      results();
    hm.done();
    frame(16'h0000, 16'h7FFE, 1'b1, 16'h458B);
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(cfg, 16'h058B);
    chk(pullOn, 1'b1);
    chk(lineOe, 1'b0);
    t_fresh();
    t_stale();
    t_mid();
    t_timeout();
    results();
  end
endmodule
bind asr_spi_slave asr_spi_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
  .clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN),
  .dataOutReadyLineO(dataOutReadyLineO),
  .dataOutReadyLineOe(dataOutReadyLineOe), .pullupOn(pullupOn),
  .cfgWord(cfgWord), .inputSel(inputSel), .cfgWrite(cfgWrite),
  .timeoutHit(timeoutHit));
`default_nettype wire
